// file: core_model.sv
// processor core model: takes a request after a set delay, ends an isr on command
// assumes the controller's request levels and one clock shared with it
`timescale 1ns/1ps
module core_model
    import vic_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // controller side
    input wire coreReq_t coreReq,
    output coreEvt_t coreEvt,
    // bench control
    input wire logic [3:0] ackDelay,
    input wire logic retCmd
);
    logic [3:0] waitCnt;

    // one ack per request, only after take has stood ackDelay cycles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt <= 4'h0;
            coreEvt <= '0;
        end else begin
            coreEvt.ret <= retCmd;
            coreEvt.ack <= coreReq.take && !coreEvt.ack && waitCnt == ackDelay;
            if (!coreReq.take || coreEvt.ack) begin
                waitCnt <= 4'h0;
            end else if (waitCnt != ackDelay) begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule

// file: vectored_irq_edge_wake_ctrl.sv
// interrupt controller: external edge inputs, wake-up request, priority gating,
// legacy vectors and vector table base/entry registers behind an apb slave
// assumes a core that pulses ack when it takes a request and ret when an isr ends
//
// What this block does
// - edge select one rising, zero falling
// - selected edge sets the input's pending flag
// - enabled external input wakes from idle/sleep
// - vector to core only with global enable
// - priority comes from per-input priority bit
// - wake request on any enabled event
// - wake ignores global, high and low enables
// - wake path is clockless combinational logic
// - table disabled when table enable is zero
// - both enables zero: fixed vector 0008h
// - no priority: bit 7 gates all interrupts
// - priority: bit 6 also gates low ones
// - bit 5 enables two levels, else high
// - edge select bits reset to rising edge
// - state field reports main/low/high nesting
// - table base 21-bit read-write, reset zero
// - entry address 21-bit read-only, reset zero
// - entry address equals base plus vector number
// - lock bit blocks writes to table base
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module vectored_irq_edge_wake_ctrl
    import vic_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external interrupt pins
    input wire logic [NUM_EXT-1:0] extPin,
    // core side
    output coreReq_t coreReq,
    input wire coreEvt_t coreEvt,
    output logic [ADDR_W-1:0] vecAddr,
    output logic wakeReq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [15:0] addr, input logic [11:0] idx);
        regHit = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic [1:0] firstSet(input logic [NUM_EXT-1:0] mask);
        firstSet = 2'd0;
        for (int i = NUM_EXT - 1; i >= 0; i--) begin
            if (mask[i]) begin
                firstSet = i[1:0];
            end
        end
    endfunction

    function automatic logic [1:0] statCode(input isrState_t s);
        unique case (s)
            ST_MAIN: statCode = 2'b00;
            ST_LOW: statCode = 2'b01;
            ST_HIGH_MAIN: statCode = 2'b10;
            ST_HIGH_LOW: statCode = 2'b11;
        endcase
    endfunction

    function automatic logic [31:0] readWord(input logic [15:0] addr, input state_t s);
        readWord = 32'h00000000;
        if (regHit(addr, IDX_LOCK)) begin
            readWord[LOCK_BIT] = s.lock;
        end else if (regHit(addr, IDX_ENTRY)) begin
            readWord[ADDR_W-1:0] = s.entry;
        end else if (regHit(addr, IDX_BASE)) begin
            readWord[ADDR_W-1:0] = s.base;
        end else if (regHit(addr, IDX_CTRL)) begin
            readWord[GIEH_BIT] = s.gieh;
            readWord[GLOBAL_LOW_ENABLE_BIT] = s.global_low_enable & s.priority_levels_enable;
            readWord[PRIORITY_LEVELS_ENABLE_BIT] = s.priority_levels_enable;
            readWord[NUM_EXT-1:0] = s.edgeSel;
        end else if (regHit(addr, IDX_STATE)) begin
            readWord[STAT_LSB+1:STAT_LSB] = statCode(s.isr);
        end else if (regHit(addr, IDX_EXT)) begin
            readWord[EXT_PEND_LSB+NUM_EXT-1:EXT_PEND_LSB] = s.pend;
            readWord[EXT_EN_LSB+NUM_EXT-1:EXT_EN_LSB] = s.en;
            readWord[EXT_PRIO_LSB+NUM_EXT-1:EXT_PRIO_LSB] = s.prio;
        end else if (regHit(addr, IDX_CFG)) begin
            readWord[MVEC_BIT] = s.mvec;
        end
    endfunction

    state_t q;
    state_t d;

    // ------------------------------------------------------------
    // edge detection on the synchronised pins
    // ------------------------------------------------------------
    logic [NUM_EXT-1:0] settled;
    logic [NUM_EXT-1:0] extEvt;

    // a change counts once stages two and three agree
    assign settled = ~(q.sync2 ^ q.sync3) & (q.sync3 ^ q.acc);
    assign extEvt = settled & ~(q.sync3 ^ q.edgeSel);

    // ------------------------------------------------------------
    // priority gating
    // ------------------------------------------------------------
    logic [NUM_EXT-1:0] effHigh;
    logic [NUM_EXT-1:0] active;
    logic [NUM_EXT-1:0] eligHigh;
    logic [NUM_EXT-1:0] eligLow;
    logic canHigh;
    logic canLow;
    logic selHigh;
    logic irqReq;
    logic [1:0] selIdx;
    logic take;
    logic [ADDR_W-1:0] entryCalc;
    logic [ADDR_W-1:0] vecCalc;

    assign effHigh = q.priority_levels_enable ? q.prio : '1;
    assign active = q.pend & q.en;
    assign eligHigh = (q.gieh ? active : '0) & effHigh;
    assign eligLow = ((q.gieh & q.global_low_enable & q.priority_levels_enable) ? active : '0) & ~effHigh;
    assign canHigh = (q.isr == ST_MAIN) || (q.isr == ST_LOW);
    assign canLow = (q.isr == ST_MAIN);
    assign selHigh = (|eligHigh) & canHigh;
    assign irqReq = selHigh | ((|eligLow) & canLow);
    assign selIdx = firstSet(selHigh ? eligHigh : eligLow);
    assign take = irqReq & coreEvt.ack;
    assign entryCalc = q.base + {13'h0000, EXT_VEC_NUM[selIdx]};

    // table vectoring versus the two fixed legacy vectors
    always_comb begin
        if (q.mvec) begin
            vecCalc = entryCalc;
        end else if (selHigh || !q.priority_levels_enable) begin
            vecCalc = LEGACY_HIGH_VEC;
        end else begin
            vecCalc = LEGACY_LOW_VEC;
        end
    end

    // ------------------------------------------------------------
    // wake-up: no clock in the path, so it works with clocks stopped
    // ------------------------------------------------------------
    assign wakeReq = |(q.en & (q.pend | ~(extPin ^ q.edgeSel)));

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic mapped;
    logic wr;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = regHit(paddr, IDX_LOCK) | regHit(paddr, IDX_ENTRY)
        | regHit(paddr, IDX_BASE) | regHit(paddr, IDX_CTRL) | regHit(paddr, IDX_STATE)
        | regHit(paddr, IDX_EXT) | regHit(paddr, IDX_CFG);
    assign wr = access & pwrite & mapped;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [NUM_EXT-1:0] pendClr;
        pendClr = '0;
        d = q;
        d.sync1 = extPin;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        d.acc = q.acc ^ settled;
        if (setup) begin
            d.prdata = readWord(paddr, q);
        end
        if (wr && regHit(paddr, IDX_CTRL) && pstrb[0]) begin
            d.gieh = pwdata[GIEH_BIT];
            d.global_low_enable = pwdata[GLOBAL_LOW_ENABLE_BIT];
            d.priority_levels_enable = pwdata[PRIORITY_LEVELS_ENABLE_BIT];
            d.edgeSel = pwdata[NUM_EXT-1:0];
        end
        if (wr && regHit(paddr, IDX_LOCK) && pstrb[0]) begin
            d.lock = pwdata[LOCK_BIT];
        end
        if (wr && regHit(paddr, IDX_BASE) && !q.lock) begin
            if (pstrb[0]) begin
                d.base[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                d.base[15:8] = pwdata[15:8];
            end
            if (pstrb[2]) begin
                d.base[ADDR_W-1:16] = pwdata[ADDR_W-1:16];
            end
        end
        if (wr && regHit(paddr, IDX_EXT)) begin
            if (pstrb[0]) begin
                pendClr = pwdata[EXT_PEND_LSB+NUM_EXT-1:EXT_PEND_LSB];
            end
            if (pstrb[1]) begin
                d.en = pwdata[EXT_EN_LSB+NUM_EXT-1:EXT_EN_LSB];
            end
            if (pstrb[2]) begin
                d.prio = pwdata[EXT_PRIO_LSB+NUM_EXT-1:EXT_PRIO_LSB];
            end
        end
        if (wr && regHit(paddr, IDX_CFG) && pstrb[0]) begin
            d.mvec = pwdata[MVEC_BIT];
        end
        // a new edge beats a clear in the same cycle
        d.pend = (q.pend & ~pendClr) | extEvt;
        if (take) begin
            d.vecOut = vecCalc;
            if (q.mvec) begin
                d.entry = entryCalc;
            end
            unique case (q.isr)
                ST_MAIN: d.isr = selHigh ? ST_HIGH_MAIN : ST_LOW;
                ST_LOW: d.isr = ST_HIGH_LOW;
                ST_HIGH_MAIN: d.isr = q.isr;
                ST_HIGH_LOW: d.isr = q.isr;
            endcase
        end else if (coreEvt.ret) begin
            d.isr = (q.isr == ST_HIGH_LOW) ? ST_LOW : ST_MAIN;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign coreReq.take = irqReq;
    assign coreReq.high = selHigh;
    assign vecAddr = q.vecOut;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence riseSettled0;
        q.edgeSel[0] && !q.acc[0] && q.sync2[0] && q.sync3[0];
    endsequence

    sequence lowRunningTake;
        (q.isr == ST_LOW) ##0 take;
    endsequence

    a_rise_sets_pend: assert property (riseSettled0 |=> q.pend[0])
        else $error("rising edge did not set pending flag 0");

    a_fall_ignored: assert property (
        (q.edgeSel[0] && q.acc[0] && !q.sync2[0] && !q.sync3[0] && !q.pend[0]
        && !wr) |=> !q.pend[0])
        else $error("falling edge set pending with rising edge selected");

    a_gie_blocks_req: assert property (!q.gieh |-> !coreReq.take)
        else $error("request raised with global enable clear");

    a_low_needs_global_low_enable: assert property (
        (coreReq.take && !coreReq.high) |-> (q.global_low_enable && q.priority_levels_enable))
        else $error("low priority request without low enable");

    a_nopri_all_high: assert property ((!q.priority_levels_enable && coreReq.take) |-> coreReq.high)
        else $error("low priority seen with priority levels off");

    a_legacy_vector: assert property (
        (take && !q.mvec && !q.priority_levels_enable) |=> (vecAddr == LEGACY_HIGH_VEC))
        else $error("legacy take did not vector to fixed address");

    a_entry_calc: assert property ((take && q.mvec) |=> (q.entry == $past(entryCalc)))
        else $error("entry address is not base plus vector number");

    a_entry_holds: assert property (!(take && q.mvec) |=> $stable(q.entry))
        else $error("entry address changed without a vectored take");

    a_lock_base: assert property (q.lock |=> $stable(q.base))
        else $error("table base changed while locked");

    a_stat_preempt: assert property (lowRunningTake |=> (q.isr == ST_HIGH_LOW))
        else $error("preemption of low isr not reported");

    a_wake_indep: assert property ((|(q.en & q.pend)) |-> wakeReq)
        else $error("enabled pending event gave no wake request");

    // ------------------------------------------------------------
    // assertions: pins and pending flags
    // ------------------------------------------------------------
    sequence fallSettled0;
        !q.edgeSel[0] && q.acc[0] && !q.sync2[0] && !q.sync3[0];
    endsequence

    a_fall_sets_pend: assert property (fallSettled0 |=> q.pend[0])
        else $error("falling edge did not set pending flag 0");

    a_pend_stays: assert property (
        (q.pend[0] && !(wr && regHit(paddr, IDX_EXT) && pstrb[0] && pwdata[EXT_PEND_LSB]))
        |=> q.pend[0])
        else $error("pending flag 0 dropped without a clear");

    a_quiet_no_pend: assert property ((!q.pend[0] && !extEvt[0]) |=> !q.pend[0])
        else $error("pending flag 0 set without an edge");

    a_edge_once: assert property (extEvt[0] |=> !extEvt[0])
        else $error("one pin edge counted twice");

    // ------------------------------------------------------------
    // assertions: gating and vectors
    // ------------------------------------------------------------
    a_take_needs_gie: assert property (take |-> q.gieh)
        else $error("interrupt taken with global enable clear");

    a_high_from_prio: assert property (
        (coreReq.take && coreReq.high && q.priority_levels_enable) |-> (|(q.pend & q.en & q.prio)))
        else $error("high request without a high priority source");

    a_table_vector: assert property (
        (take && q.mvec) |=> (vecAddr == $past(entryCalc)))
        else $error("table take did not branch to the entry address");

    a_legacy_low: assert property (
        (take && !q.mvec && q.priority_levels_enable && !selHigh) |=> (vecAddr == LEGACY_LOW_VEC))
        else $error("legacy low take did not use the low vector");

    a_legacy_entry: assert property ((take && !q.mvec) |=> $stable(q.entry))
        else $error("entry address changed with the table disabled");

    a_base_low_lane: assert property (
        (wr && regHit(paddr, IDX_BASE) && !q.lock && pstrb[0])
        |=> (q.base[7:0] == $past(pwdata[7:0])))
        else $error("table base low byte not written");

    // ------------------------------------------------------------
    // assertions: wake-up and nesting state
    // ------------------------------------------------------------
    sequence mainHighTake;
        (q.isr == ST_MAIN) ##0 take ##0 selHigh;
    endsequence

    sequence highLowReturn;
        (q.isr == ST_HIGH_LOW) ##0 coreEvt.ret ##0 !take;
    endsequence

    a_wake_pin_level: assert property (
        (q.en[0] && (extPin[0] == q.edgeSel[0])) |-> wakeReq)
        else $error("selected pin level gave no wake request");

    a_wake_needs_en: assert property (wakeReq |-> (|q.en))
        else $error("wake request with no input enabled");

    a_stat_high_main: assert property (mainHighTake |=> (q.isr == ST_HIGH_MAIN))
        else $error("high isr from main not reported");

    a_stat_return: assert property (highLowReturn |=> (q.isr == ST_LOW))
        else $error("return from preempting isr did not resume low isr");

    a_no_req_high: assert property (
        ((q.isr == ST_HIGH_MAIN) || (q.isr == ST_HIGH_LOW)) |-> !coreReq.take)
        else $error("request raised while a high isr runs");

endmodule

// file: vectored_irq_edge_wake_ctrl_test.sv
// self-checking bench of the interrupt controller: registers, edges, wake, vectors
// assumes the design package, the core model and a 200 MHz clock
`timescale 1ns/1ps
module vectored_irq_edge_wake_ctrl_test;
    import vic_pkg::*;

    logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata, rdData;
    logic pready, pslverr, wakeReq, rdErr, retCmd = 1'b0;
    logic [NUM_EXT-1:0] extPin = 3'h0;
    logic [ADDR_W-1:0] vecAddr;
    logic [3:0] ackDelay = 4'h0;
    logic [3:0] pstrb = 4'hf;
    coreReq_t coreReq;
    coreEvt_t coreEvt;
    int miscompares = 0;
    int samplesChecked = 0;

    always #2.5 core_clk = ~core_clk;

    vectored_irq_edge_wake_ctrl dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .extPin(extPin),
        .coreReq(coreReq), .coreEvt(coreEvt), .vecAddr(vecAddr), .wakeReq(wakeReq));
    core_model core (.core_clk(core_clk), .nrst(nrst), .coreReq(coreReq),
        .coreEvt(coreEvt), .ackDelay(ackDelay), .retCmd(retCmd));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        check("zero wait", pready, 1'b1);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(name, rdData, exp);
    endtask

    task automatic setExt(input logic [2:0] en, input logic [2:0] prio, input logic [2:0] clr);
        apb(1'b1, IDX_EXT, {13'h0000, prio, 5'h00, en, 5'h00, clr});
    endtask

    task automatic pinTo(input int i, input logic v);
        extPin[i] <= v;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic retPulse;
        retCmd <= 1'b1;
        @(posedge core_clk);
        retCmd <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    // waits for the core to take a request, then checks vector and nesting state
    task automatic taken(input string name, input logic [ADDR_W-1:0] vec, input logic [31:0] st);
        int n;
        n = 0;
        while (coreEvt.ack !== 1'b1 && n < 40) begin
            n++;
            @(posedge core_clk);
        end
        check("ack seen", coreEvt.ack, 1'b1);
        #1;
        check(name, vecAddr, vec);
        @(posedge core_clk);
        chk(name, IDX_STATE, st);
    endtask

    task automatic testRegs;
        chk("ctrl reset", IDX_CTRL, 32'h00000007);
        chk("state reset", IDX_STATE, 32'h0);
        chk("entry reset", IDX_ENTRY, 32'h0);
        chk("base reset", IDX_BASE, 32'h0);
        apb(1'b0, 12'h4ff, 32'h0);
        check("unmapped error", rdErr, 1'b1);
        apb(1'b1, IDX_CTRL, 32'h00000047);
        chk("low enable hidden", IDX_CTRL, 32'h00000007);
        apb(1'b1, IDX_BASE, 32'hffffffff);
        chk("base width", IDX_BASE, 32'h001fffff);
        pstrb <= 4'h1;
        apb(1'b1, IDX_BASE, 32'h0);
        pstrb <= 4'hf;
        chk("base low lane", IDX_BASE, 32'h001fff00);
        apb(1'b1, IDX_ENTRY, 32'h00000123);
        chk("entry read only", IDX_ENTRY, 32'h0);
        apb(1'b1, IDX_LOCK, 32'h1);
        apb(1'b1, IDX_BASE, 32'h55);
        chk("base locked", IDX_BASE, 32'h001fff00);
        apb(1'b1, IDX_LOCK, 32'h0);
        apb(1'b1, IDX_BASE, 32'h100);
        chk("base unlocked", IDX_BASE, 32'h100);
    endtask

    task automatic testEdges;
        for (int i = 0; i < NUM_EXT; i++) begin
            apb(1'b1, IDX_CTRL, 32'h7);
            pinTo(i, 1'b1);
            chk("rising taken", IDX_EXT, 32'h00070000 | (32'h1 << i));
            setExt(3'h0, 3'h7, 3'h7);
            apb(1'b1, IDX_CTRL, 32'h0);
            pinTo(i, 1'b0);
            chk("falling taken", IDX_EXT, 32'h00070000 | (32'h1 << i));
            setExt(3'h0, 3'h7, 3'h7);
            pinTo(i, 1'b1);
            chk("rising ignored", IDX_EXT, 32'h00070000);
            apb(1'b1, IDX_CTRL, 32'h7);
            pinTo(i, 1'b0);
            chk("falling ignored", IDX_EXT, 32'h00070000);
        end
    endtask

    task automatic testWake;
        setExt(3'h1, 3'h7, 3'h7);
        check("wake idle", wakeReq, 1'b0);
        extPin[0] <= 1'b1;
        #1;
        check("wake without clock", wakeReq, 1'b1);
        repeat (6) @(posedge core_clk);
        check("wake no global", wakeReq, 1'b1);
        check("no take without global", coreReq.take, 1'b0);
        setExt(3'h0, 3'h7, 3'h7);
        check("wake disabled", wakeReq, 1'b0);
        pinTo(0, 1'b0);
    endtask

    task automatic testVector;
        apb(1'b1, IDX_CTRL, 32'h87);
        setExt(3'h4, 3'h7, 3'h7);
        extPin[2] <= 1'b1;
        taken("table vector", 21'h00010a, 32'h80);
        chk("entry updated", IDX_ENTRY, 32'h0000010a);
        setExt(3'h4, 3'h7, 3'h7);
        retPulse;
        chk("main again", IDX_STATE, 32'h0);
        apb(1'b1, IDX_CFG, 32'h0);
        setExt(3'h1, 3'h6, 3'h7);
        extPin[0] <= 1'b1;
        taken("legacy single", 21'h000008, 32'h80);
        chk("entry held", IDX_ENTRY, 32'h0000010a);
        setExt(3'h1, 3'h6, 3'h7);
        retPulse;
        apb(1'b1, IDX_CTRL, 32'ha7);
        pinTo(0, 1'b0);
        pinTo(0, 1'b1);
        check("low held back", coreReq.take, 1'b0);
        ackDelay <= 4'h3;
        apb(1'b1, IDX_CTRL, 32'he7);
        check("low request", coreReq.take, 1'b1);
        check("low not high", coreReq.high, 1'b0);
        taken("legacy low", 21'h000018, 32'h40);
        setExt(3'h3, 3'h2, 3'h1);
        extPin[1] <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("preempt request", coreReq.take, 1'b1);
        check("preempt high", coreReq.high, 1'b1);
        taken("preempt", 21'h000008, 32'hc0);
        setExt(3'h3, 3'h2, 3'h2);
        retPulse;
        chk("back to low", IDX_STATE, 32'h40);
        retPulse;
        chk("back to main", IDX_STATE, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        testRegs;
        testEdges;
        testWake;
        testVector;
        test_done;
    end

    // cuts a hang short: the whole run needs far fewer cycles
    initial begin
        #50000;
        miscompares++;
        test_done;
    end
endmodule

// file: vic_pkg.sv
// constants, types and register map of the edge-triggered vectored interrupt controller
// assumes an apb master on core_clk and a core that acknowledges and returns from isrs
package vic_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_EXT = 3;
    localparam int ADDR_W = 21;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_LOCK = 12'h459;
    localparam logic [11:0] IDX_ENTRY = 12'h45a;
    localparam logic [11:0] IDX_BASE = 12'h45d;
    localparam logic [11:0] IDX_CTRL = 12'h4d6;
    localparam logic [11:0] IDX_STATE = 12'h4d7;
    localparam logic [11:0] IDX_EXT = 12'h4e0;
    localparam logic [11:0] IDX_CFG = 12'h4e1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GIEH_BIT = 7;
    localparam int GLOBAL_LOW_ENABLE_BIT = 6;
    localparam int PRIORITY_LEVELS_ENABLE_BIT = 5;
    localparam int STAT_LSB = 6;
    localparam int LOCK_BIT = 0;
    localparam int MVEC_BIT = 0;
    localparam int EXT_PEND_LSB = 0;
    localparam int EXT_EN_LSB = 8;
    localparam int EXT_PRIO_LSB = 16;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [NUM_EXT-1:0] EDGE_RST = 3'h7;
    localparam logic [NUM_EXT-1:0] PRIO_RST = 3'h7;
    localparam logic MVEC_RST = 1'h1;
    localparam logic [ADDR_W-1:0] BASE_RST = 21'h000000;
    localparam logic [ADDR_W-1:0] ENTRY_RST = 21'h000000;

    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LEGACY_HIGH_VEC = 21'h000008;
    localparam logic [ADDR_W-1:0] LEGACY_LOW_VEC = 21'h000018;
    localparam logic [NUM_EXT-1:0][7:0] EXT_VEC_NUM = {8'h0a, 8'h09, 8'h08};

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_MAIN, ST_LOW, ST_HIGH_MAIN, ST_HIGH_LOW} isrState_t;

    typedef struct packed {
        logic take;
        logic high;
    } coreReq_t;

    typedef struct packed {
        logic ack;
        logic ret;
    } coreEvt_t;

    typedef struct packed {
        logic [NUM_EXT-1:0] sync1;
        logic [NUM_EXT-1:0] sync2;
        logic [NUM_EXT-1:0] sync3;
        logic [NUM_EXT-1:0] acc;
        logic [NUM_EXT-1:0] pend;
        logic [NUM_EXT-1:0] en;
        logic [NUM_EXT-1:0] prio;
        logic [NUM_EXT-1:0] edgeSel;
        logic gieh;
        logic global_low_enable;
        logic priority_levels_enable;
        logic mvec;
        logic lock;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] entry;
        logic [ADDR_W-1:0] vecOut;
        isrState_t isr;
        logic [31:0] prdata;
    } state_t;

    localparam state_t STATE_RST = '{
        sync1: '0, sync2: '0, sync3: '0, acc: '0, pend: '0, en: '0,
        prio: PRIO_RST, edgeSel: EDGE_RST, gieh: 1'b0, global_low_enable: 1'b0, priority_levels_enable: 1'b0,
        mvec: MVEC_RST, lock: 1'b0, base: BASE_RST, entry: ENTRY_RST,
        vecOut: ENTRY_RST, isr: ST_MAIN, prdata: 32'h00000000};

endpackage
